// file: hdl/acs_seq.sv
// conversion sequencer with host read/write framing
`default_nettype none
// Overview of operation
// - auto-zero lasts 78 clocks, full calibration 4946 clocks
// - timing-source select 0 is sync-out mode; conversion lasts 44 clocks
// - acquisition programmable 9 to 79 clocks; 9 gives about 222 kHz
// - bus width select 0: results leave over eight data lines
// - bus width select 1: full signed 13-bit result in one transfer
module acs_seq
  import acs_pkg::*;
#(
  parameter int unsigned DW    = DATA_W,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic              i_ref_clk,          // converter clock
  input  wire logic              i_rst,              // sync reset, high
  input  wire acs_strb_s         i_strb,             // host cs/rd/wr
  input  wire logic [DW-1:0]     i_data,             // data bus in
  output logic [DW-1:0]          o_data,             // data bus out
  output logic                   o_data_oe,          // data bus drive
  input  wire logic              i_timing_sel,       // 0 sync-out, 1 sync-in
  input  wire logic              i_bus_width_select, // 0 8-bit, 1 13-bit
  input  wire logic [ACQ_W-1:0]  i_acq_clks,         // acquisition clocks
  input  wire logic [DW-1:0]     i_sample,           // comparator result
  input  wire logic              i_sync,             // sync-in level
  output logic                   o_sync,             // sync-out, high in conv in sync-out mode only
  output logic                   o_rdy_n,            // result waiting, low
  output logic                   o_busy              // not idle
);
  acs_state_e        state_r;
  acs_state_e        state_nxt;
  logic [CNT_W-1:0]  cnt_r;
  logic [CNT_W-1:0]  cnt_nxt;
  logic [CNT_W-1:0]  acq_len_r;
  logic [CNT_W-1:0]  ph_cnt_r;
  acs_strb_s         strb_d_r;
  logic              sync_d_r;
  logic              run_r;
  logic              zero_req_r;
  logic              cal_req_r;
  logic              byte_hi_r;
  logic              o_data_oe_r;
  logic [DW-1:0]     o_data_r;
  logic              o_sync_r;
  logic              o_rdy_n_r;
  logic              o_busy_r;
  logic              wr_act;
  logic              rd_fall;
  logic              rd_rise;
  logic              sync_edge;
  logic              done;
  logic              push;
  logic              can_go;
  logic              f_in_ready;
  logic              f_out_valid;
  logic              f_pop;
  logic [DW-1:0]     f_head;
  logic [$clog2(DEPTH):0] f_level;

  function automatic logic [CNT_W-1:0] acq_clamp(input logic [ACQ_W-1:0] n);
    logic [ACQ_W-1:0] v;
    v = n;
    if (n < ACQ_MIN) begin
      v = ACQ_MIN;
    end else if (n > ACQ_MAX) begin
      v = ACQ_MAX;
    end
    return {{(CNT_W-ACQ_W){1'b0}}, v};
  endfunction

  // strobes taken on their edges only while chip select is low
  assign wr_act    = ~i_strb.cs_n & i_strb.wr_n & ~strb_d_r.wr_n;
  assign rd_fall   = ~i_strb.cs_n & ~i_strb.rd_n & strb_d_r.rd_n;
  assign rd_rise   = ~i_strb.cs_n & i_strb.rd_n & ~strb_d_r.rd_n;
  assign sync_edge = i_sync & ~sync_d_r;
  assign done      = (cnt_r == '0);
  assign push      = (state_r == ACS_CONV) & done;
  // room must remain after any push landing this cycle
  assign can_go    = run_r & ((f_level + (($clog2(DEPTH)+1)'(push)))
                     < ($clog2(DEPTH)+1)'(DEPTH))
                     & ((i_timing_sel == TSEL_SYNC_OUT) | sync_edge);
  assign f_pop     = rd_rise & (i_bus_width_select | byte_hi_r);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = done ? cnt_r : cnt_r - 1'b1;
    unique case (state_r)
      ACS_IDLE, ACS_CONV: begin
        if (state_r == ACS_CONV && !done) begin
          state_nxt = ACS_CONV;
        end else if (cal_req_r) begin
          state_nxt = ACS_CAL;
          cnt_nxt   = CAL_CLKS - 1'b1;
        end else if (zero_req_r) begin
          state_nxt = ACS_ZERO;
          cnt_nxt   = ZERO_CLKS - 1'b1;
        end else if (can_go) begin
          state_nxt = ACS_ACQ;
          cnt_nxt   = acq_clamp(i_acq_clks) - 1'b1;
        end else begin
          state_nxt = ACS_IDLE;
        end
      end
      ACS_ZERO, ACS_CAL: begin
        if (done) begin
          state_nxt = ACS_IDLE;
        end
      end
      ACS_ACQ: begin
        if (done) begin
          state_nxt = ACS_CONV;
          cnt_nxt   = CONV_CLKS - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_r   <= ACS_IDLE;
      cnt_r     <= '0;
      acq_len_r <= '0;
      ph_cnt_r  <= '0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      ph_cnt_r <= (state_nxt != state_r) ? '0 : ph_cnt_r + 1'b1;
      if (state_nxt == ACS_ACQ && state_r != ACS_ACQ) begin
        acq_len_r <= acq_clamp(i_acq_clks);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      strb_d_r <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
      sync_d_r <= 1'b0;
    end else begin
      strb_d_r <= i_strb;
      sync_d_r <= i_sync;
    end
  end

  // command flags; a new request beats the clear on starting
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      run_r      <= 1'b0;
      zero_req_r <= 1'b0;
      cal_req_r  <= 1'b0;
    end else begin
      if (state_nxt == ACS_ZERO && state_r != ACS_ZERO) begin
        zero_req_r <= 1'b0;
      end
      if (state_nxt == ACS_CAL && state_r != ACS_CAL) begin
        cal_req_r <= 1'b0;
      end
      if (wr_act) begin
        unique case (acs_cmd_e'(i_data[1:0]))
          ACS_CMD_STOP: run_r      <= 1'b0;
          ACS_CMD_RUN:  run_r      <= 1'b1;
          ACS_CMD_ZERO: zero_req_r <= 1'b1;
          ACS_CMD_CAL:  cal_req_r  <= 1'b1;
        endcase
      end
    end
  end

  // 8-bit mode: low byte first, then sign-extended high byte
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_data_r    <= '0;
      o_data_oe_r <= 1'b0;
      byte_hi_r   <= 1'b0;
    end else begin
      if (rd_fall) begin
        o_data_oe_r <= 1'b1;
        if (i_bus_width_select == BW_13BIT) begin
          o_data_r <= f_head;
        end else if (!byte_hi_r) begin
          o_data_r <= {{(DW-BYTE_W){1'b0}}, f_head[BYTE_W-1:0]};
        end else begin
          o_data_r <= {{(DW-BYTE_W){1'b0}}, {(2*BYTE_W-DW){f_head[DW-1]}},
                       f_head[DW-1:BYTE_W]};
        end
      end else if (i_strb.rd_n || i_strb.cs_n) begin
        o_data_oe_r <= 1'b0;
      end
      if (i_bus_width_select == BW_13BIT) begin
        byte_hi_r <= 1'b0;
      end else if (rd_rise) begin
        byte_hi_r <= ~byte_hi_r;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_sync_r  <= 1'b0;
      o_rdy_n_r <= 1'b1;
      o_busy_r  <= 1'b0;
    end else begin
      o_sync_r  <= (state_nxt == ACS_CONV) & (i_timing_sel == TSEL_SYNC_OUT);
      o_rdy_n_r <= ~f_out_valid;
      o_busy_r  <= (state_nxt != ACS_IDLE);
    end
  end

  assign o_data    = o_data_r;
  assign o_data_oe = o_data_oe_r;
  assign o_sync    = o_sync_r;
  assign o_rdy_n   = o_rdy_n_r;
  assign o_busy    = o_busy_r;

  // stalls acquisition start when full, so a slow host loses no result
  acs_fifo #(
    .W (DW),
    .D (DEPTH)
  ) u_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_rst       (i_rst),
    .i_in_valid  (push),
    .o_in_ready  (f_in_ready),
    .i_in_data   (i_sample),
    .o_out_valid (f_out_valid),
    .i_out_ready (f_pop),
    .o_out_data  (f_head),
    .o_level     (f_level)
  );

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_zero_len : assert property (
    (state_r == ACS_ZERO && state_nxt != ACS_ZERO) |-> ph_cnt_r == ZERO_CLKS - 1'b1)
    else $error("auto-zero length wrong");
  a_cal_len : assert property (
    (state_r == ACS_CAL && state_nxt != ACS_CAL) |-> ph_cnt_r == CAL_CLKS - 1'b1)
    else $error("calibration length wrong");
  a_conv_len : assert property (
    $rose(state_r == ACS_CONV) |-> (state_r == ACS_CONV) [*8] ##36 push)
    else $error("conversion length wrong");
  a_sync_out_level : assert property (
    $rose(state_r == ACS_CONV) && $past(i_timing_sel) == TSEL_SYNC_OUT |-> o_sync_r)
    else $error("sync-out missing during conversion");
  a_acq_len : assert property (
    (state_r == ACS_ACQ && state_nxt == ACS_CONV) |-> ph_cnt_r == acq_len_r - 1'b1
      && acq_len_r >= ACQ_MIN && acq_len_r <= ACQ_MAX)
    else $error("acquisition length wrong");
  a_byte_mode : assert property (
    rd_fall && i_bus_width_select == BW_8BIT && !byte_hi_r |=>
      o_data_oe_r && o_data_r == {{(DW-BYTE_W){1'b0}}, $past(f_head[BYTE_W-1:0])})
    else $error("low byte not presented");
  a_word_mode : assert property (
    rd_fall && i_bus_width_select == BW_13BIT |=> o_data_oe_r && o_data_r == $past(f_head))
    else $error("full word not presented");
  a_conv_after_acq : assert property (
    $rose(state_r == ACS_CONV) |-> $past(state_r) == ACS_ACQ)
    else $error("conversion without acquisition");
  a_acq_after_conv : assert property (
    $rose(state_r == ACS_ACQ) |-> $past(state_r) == ACS_IDLE || $past(push))
    else $error("acquisition overlaps conversion");
  a_write_framed : assert property (
    $changed(run_r) |-> $past(!i_strb.cs_n && i_strb.wr_n && !strb_d_r.wr_n))
    else $error("run state changed without a framed write");

  c_cal_done   : cover property (state_r == ACS_CAL && state_nxt == ACS_IDLE);
  c_sample     : cover property (push ##1 state_r == ACS_ACQ);
  c_byte_pair  : cover property (rd_rise && byte_hi_r && !i_bus_width_select);
  c_fifo_full  : cover property (!f_in_ready);
endmodule
`default_nettype wire

// file: hdl/acs_pkg.sv
// constants and types shared by the conversion sequencer files
`default_nettype none
package acs_pkg;
  localparam int unsigned DATA_W     = 13;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned CNT_W      = 13;
  localparam int unsigned ACQ_W      = 7;
  // phase lengths in converter clocks
  localparam logic [12:0] ZERO_CLKS  = 13'h004E;
  localparam logic [12:0] CAL_CLKS   = 13'h1352;
  localparam logic [12:0] CONV_CLKS  = 13'h002C;
  localparam logic [6:0]  ACQ_MIN    = 7'h09;
  localparam logic [6:0]  ACQ_MAX    = 7'h4F;
  localparam logic        TSEL_SYNC_OUT = 1'h0;
  localparam logic        BW_8BIT    = 1'h0;
  localparam logic        BW_13BIT   = 1'h1;
  typedef enum logic [1:0] {
    ACS_CMD_STOP = 2'h0,
    ACS_CMD_RUN  = 2'h1,
    ACS_CMD_ZERO = 2'h2,
    ACS_CMD_CAL  = 2'h3
  } acs_cmd_e;
  typedef enum logic [4:0] {
    ACS_IDLE = 5'b00001,
    ACS_ZERO = 5'b00010,
    ACS_CAL  = 5'b00100,
    ACS_ACQ  = 5'b01000,
    ACS_CONV = 5'b10000
  } acs_state_e;
  // host strobes, all active low
  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
  } acs_strb_s;
endpackage
`default_nettype wire

// file: hdl/acs_fifo.sv
// result fifo between the sequencer and the host read port
`default_nettype none
module acs_fifo #(
  parameter int unsigned W = 13,
  parameter int unsigned D = 32
) (
  input  wire logic                 i_ref_clk,   // clock
  input  wire logic                 i_rst,       // sync reset
  input  wire logic                 i_in_valid,  // push request
  output logic                      o_in_ready,  // not full
  input  wire logic [W-1:0]         i_in_data,   // pushed word
  output logic                      o_out_valid, // not empty
  input  wire logic                 i_out_ready, // pop request
  output logic [W-1:0]              o_out_data,  // head word
  output logic [$clog2(D):0]        o_level      // words held
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0]  mem_r [D];
  logic [AW:0]   wptr_r;
  logic [AW:0]   rptr_r;
  logic          push;
  logic          pop;

  assign o_level     = wptr_r - rptr_r;
  assign o_in_ready  = (o_level != (AW+1)'(D));
  assign o_out_valid = (wptr_r != rptr_r);
  assign o_out_data  = mem_r[rptr_r[AW-1:0]];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = i_out_ready & o_out_valid;

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem_r[wptr_r[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
    end
  end

  a_fifo_bound : assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_level <= (AW+1)'(D)) else $error("fifo level beyond depth");
endmodule
`default_nettype wire

// file: bench/acs_host.sv
// host bus model: chip select, read and write strobes, data bus
`default_nettype none
module acs_host
  import acs_pkg::*;
(
  input  wire logic         i_ref_clk, // converter clock
  input  wire logic         i_ack,     // device driving the bus
  output var acs_strb_s     o_strb,    // cs/rd/wr, active low
  output logic [DATA_W-1:0] o_data     // bus value toward device
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_strb = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
    o_data = 13'h0000;
  end
  task automatic write_cmd(input logic [1:0] cmd);
    @(negedge i_ref_clk);
    o_strb = '{cs_n: 1'b0, rd_n: 1'b1, wr_n: 1'b0};
    o_data = {11'h000, cmd};
    @(negedge i_ref_clk);
    o_strb.wr_n = 1'b1;
    @(negedge i_ref_clk);
    o_strb.cs_n = 1'b1;
    // released bus must not keep showing the command
    o_data = ~o_data;
  endtask
  task automatic read_word();
    int n;
    n = 0;
    @(negedge i_ref_clk);
    o_strb = '{cs_n: 1'b0, rd_n: 1'b0, wr_n: 1'b1};
    do begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end while (i_ack !== 1'b1 && n < 8);
    @(negedge i_ref_clk);
    o_strb.rd_n = 1'b1;
    @(negedge i_ref_clk);
    o_strb.cs_n = 1'b1;
    @(negedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench for the conversion sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import acs_pkg::*;
  logic             i_ref_clk;
  logic             i_rst;
  acs_strb_s        strb;
  logic [12:0]      hdata;
  logic [12:0]      o_data;
  logic             data_oe;
  logic             timing_sel;
  logic             bus_width_select;
  logic [6:0]       acq_clks;
  logic [12:0]      sample = 13'h0000;
  logic             sync_in = 1'b0;
  logic             sync_out;
  logic             rdy_n;
  logic             busy;
  logic             sync_d = 1'b0;
  logic             oe_d = 1'b0;
  logic [12:0]      samp_q[$];
  logic [12:0]      exp_q[$];
  logic [12:0]      s;
  int               num_errors = 0;
  int               checks = 0;
  int               seed = 82014;
  int               cyc = 0;
  int               busy_run = 0;
  int               busy_len = 0;
  int               sync_run = 0;
  int               lo_len = 0;
  int               hi_len = 0;
  int               convs = 0;
  int               sync_hi_in = 0;
  acs_seq dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_strb(strb), .i_data(hdata),
    .o_data(o_data), .o_data_oe(data_oe), .i_timing_sel(timing_sel),
    .i_bus_width_select(bus_width_select), .i_acq_clks(acq_clks), .i_sample(sample),
    .i_sync(sync_in), .o_sync(sync_out), .o_rdy_n(rdy_n), .o_busy(busy));
  acs_host host (.i_ref_clk(i_ref_clk), .i_ack(data_oe), .o_strb(strb), .o_data(hdata));
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  task automatic test_done();
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [12:0] got, input logic [12:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(negedge i_ref_clk);
    while (busy === 1'b1 && n < 6000) begin
      @(negedge i_ref_clk);
      n++;
    end
    // a sequencer that never goes idle is a failure
    if (busy === 1'b1) begin
      num_errors++;
    end
    @(negedge i_ref_clk);
  endtask
  task automatic next_conv();
    int c;
    int n;
    c = convs;
    n = 0;
    while (convs == c && n < 200) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (convs == c) begin
      num_errors++;
    end
    @(negedge i_ref_clk);
  endtask
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      test_done();
    end
  end
  // run lengths, sample stimulus and read comparison; outputs settle by the falling edge
  always @(negedge i_ref_clk) begin
    if (busy === 1'b1) begin
      busy_run++;
    end else if (busy_run != 0) begin
      busy_len = busy_run;
      busy_run = 0;
    end
    if (sync_out === 1'b1 && !sync_d) begin
      lo_len = sync_run;
      sync_run = 0;
      // new sample stays still for the whole conversion
      sample = 13'($random(seed));
      samp_q.push_back(sample);
      convs++;
    end else if (sync_out !== 1'b1 && sync_d) begin
      hi_len = sync_run;
      sync_run = 0;
    end
    sync_run++;
    sync_d = (sync_out === 1'b1);
    sync_in = 1'($random(seed));
    if (timing_sel === 1'b1 && sync_out === 1'b1) begin
      sync_hi_in++;
    end
    if (data_oe === 1'b1 && !oe_d) begin
      chk("read data", o_data, exp_q.pop_front());
    end
    oe_d = (data_oe === 1'b1);
  end
  initial begin
    i_rst = 1'b1;
    timing_sel = TSEL_SYNC_OUT;
    bus_width_select = BW_13BIT;
    acq_clks = ACQ_MIN;
    repeat (10) @(negedge i_ref_clk);
    i_rst = 1'b0;
    host.write_cmd(2'h2);
    wait_idle();
    chk("auto-zero clocks", 13'(busy_len), ZERO_CLKS);
    host.write_cmd(2'h3);
    wait_idle();
    chk("calibration clocks", 13'(busy_len), CAL_CLKS);
    host.write_cmd(2'h1);
    repeat (3) next_conv();
    chk("acquisition clocks", 13'(lo_len), 13'(ACQ_MIN));
    chk("conversion clocks", 13'(hi_len), CONV_CLKS);
    acq_clks = ACQ_MIN + 7'($unsigned($random(seed)) % 71);
    repeat (2) next_conv();
    chk("programmed acquisition", 13'(lo_len), 13'(acq_clks));
    while (convs < 32 && cyc < 20000) next_conv();
    // fifo full: sequencer must hold off the next acquisition
    repeat (200) @(negedge i_ref_clk);
    chk("conversions held", 13'(convs), 13'h0020);
    chk("result waiting", {12'h000, rdy_n}, 13'h0000);
    host.write_cmd(2'h0);
    for (int i = 0; i < 16; i++) begin
      exp_q.push_back(samp_q.pop_front());
      host.read_word();
    end
    bus_width_select = BW_8BIT;
    for (int i = 0; i < 16; i++) begin
      s = samp_q.pop_front();
      exp_q.push_back({5'h00, s[7:0]});
      exp_q.push_back({5'h00, {3{s[12]}}, s[12:8]});
      host.read_word();
      host.read_word();
    end
    repeat (3) @(negedge i_ref_clk);
    chk("fifo drained", {12'h000, rdy_n}, 13'h0001);
    // sync-in: samples start on sync input edges, sample input held still
    timing_sel = ~TSEL_SYNC_OUT;
    bus_width_select = BW_13BIT;
    host.write_cmd(2'h1);
    repeat (300) @(negedge i_ref_clk);
    host.write_cmd(2'h0);
    wait_idle();
    chk("sync-in results", {12'h000, rdy_n}, 13'h0000);
    chk("sync-out quiet", 13'(sync_hi_in), 13'h0000);
    exp_q.push_back(sample);
    host.read_word();
    repeat (3) @(negedge i_ref_clk);
    // a read that never saw the bus driven leaves its note behind
    chk("reads answered", 13'(exp_q.size()), 13'h0000);
    test_done();
  end
endmodule
`default_nettype wire
